//--- rtl/nis_pkg.sv
// Shared constants, state codes and the level decode of the nested
// interrupt and stack sequencer.
// Assumes an 8-bit CPU core drives the instruction-side strobes.
package nis_pkg;

    // ------------------------------------------------------------
    // Sizes and addresses
    // ------------------------------------------------------------
    localparam int NUM_VEC = 14;
    localparam int MASKABLE_VEC = 13;
    localparam int VEC_IDX_W = 4;
    localparam int PRIO_REGS = 4;
    localparam logic [15:0] SP_RESET = 16'h017f;
    localparam logic [15:0] RESET_VECTOR = 16'hfffe;
    localparam logic [15:0] TRAP_VECTOR = 16'hfffc;
    localparam logic [15:0] VECTOR_TOP = 16'hfffa;
    localparam logic [2:0] IRQ_CTX_BYTES = 3'h5;
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] VEC_BYTES = 3'h2;

    // ------------------------------------------------------------
    // Condition code mask bits and level encodings
    // ------------------------------------------------------------
    localparam int LEVEL_BIT_HIGH_POS = 5;
    localparam int LEVEL_BIT_LOW_POS = 3;
    localparam logic [1:0] LEVEL0_CODE = 2'h2;
    localparam logic [1:0] LEVEL1_CODE = 2'h1;
    localparam logic [1:0] LEVEL2_CODE = 2'h0;
    localparam logic [1:0] LEVEL3_CODE = 2'h3;
    localparam logic [7:0] PRIO_RESET = 8'hff;
    localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_IRQ_PUSH = 3'h1,
        ST_CALL_PUSH = 3'h2,
        ST_RTI_POP = 3'h3,
        ST_RET_POP = 3'h4,
        ST_VEC_FETCH = 3'h5
    } nis_state_type;

    // Two-bit mask code to numeric level, 0 lowest and 3 highest
    function automatic logic [1:0] level_of(input logic [1:0] code);
        logic [1:0] lvl;
        lvl = 2'h0;
        unique case (code)
            LEVEL0_CODE: lvl = 2'h0;
            LEVEL1_CODE: lvl = 2'h1;
            LEVEL2_CODE: lvl = 2'h2;
            LEVEL3_CODE: lvl = 2'h3;
        endcase
        return lvl;
    endfunction

endpackage

//--- rtl/nis_arbiter.sv
// Combinational arbiter over the maskable vectors.
// Assumes index 0 is the highest fixed hardware priority.
module nis_arbiter #(
    parameter int N = 13,
    parameter int W = 4
) (
    input wire logic [N-1:0] pending,
    input wire logic [N-1:0] enable,
    input wire logic [2*N-1:0] codes,
    input wire logic [1:0] cur_code,
    output logic grant,
    output logic [W-1:0] index,
    output logic [1:0] code
);

    logic [N-1:0] eligible;
    logic [1:0] best;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            // Only a level strictly above the running one may nest
            assign eligible[g] = pending[g] & enable[g] &
                (nis_pkg::level_of(codes[2*g+:2]) >
                 nis_pkg::level_of(cur_code)); // [RULE23]
        end
    endgenerate

    // Walk from lowest hardware priority so ties go to the lower index
    always_comb begin
        grant = 1'b0;
        index = '0;
        code = nis_pkg::LEVEL0_CODE;
        best = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i] && (!grant ||
                nis_pkg::level_of(codes[2*i+:2]) >= best)) begin // [RULE18]
                grant = 1'b1;
                best = nis_pkg::level_of(codes[2*i+:2]);
                index = W'(i);
                code = codes[2*i+:2];
            end
        end
    end

endmodule

//--- rtl/nis_sequencer.sv
// Nested interrupt controller with stack pointer and context stacking.
// Assumes a byte memory with combinational read data and a CPU core
// that strobes its stack instructions only while busy is low.

// Summary of operation
// [RULE1] 16-bit pointer addresses next free byte, resets 017Fh
// [RULE2] Decrement after push, increment before pop
// [RULE3] Upper nine pointer bits fixed by hardware
// [RULE4] Reset and stack reset set low seven bits
// [RULE5] Pointer wraps silently both ways
// [RULE6] Low pointer byte readable and loadable
// [RULE7] Program counter low goes first, rest follow
// [RULE8] Call uses two bytes, interrupt five
// [RULE9] Entry waits for current instruction end
// [RULE10] Stack program counter, X, accumulator, condition code
// [RULE11] Load mask bits with serviced vector level
// [RULE12] Load program counter from vector, fetch handler
// [RULE13] Return pops context including both mask bits
// [RULE14] Level codes 10, 01, 00, 11; 11 highest
// [RULE15] Mask kept in condition code bits 5, 3
// [RULE16] Sixteen vectors FFE0h to FFFFh by priority
// [RULE17] Reset fetches start address from FFFEh, FFFFh
// [RULE18] Highest level wins, then hardware priority
// [RULE19] Unserviced requests stay latched until highest
// [RULE20] Reset, trap, pin interrupt rank highest
// [RULE21] Up to four nesting levels
// [RULE22] Non-maskable ignore mask, then set level 3
// [RULE23] Maskable needs enable and level above mask
// [RULE24] Priority field write of level 0 ignored
// [RULE25] Push PROGRAM_COUNTER_LOW_BYTE, PROGRAM_COUNTER_HIGH_BYTE, X, A, CC; pop reversed
module nis_sequencer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_done,
    input wire logic [nis_pkg::MASKABLE_VEC-1:0] irq_req,
    input wire logic [nis_pkg::MASKABLE_VEC-1:0] irq_enable,
    input wire logic top_level_pin_interrupt,
    input wire logic trap_req,
    input wire logic call_req,
    input wire logic ret_req,
    input wire logic return_from_handler_instruction,
    input wire logic stack_reset_instruction,
    input wire logic sp_load,
    input wire logic [7:0] sp_load_data,
    input wire logic mask_load,
    input wire logic [1:0] mask_load_data,
    input wire logic prio_wr,
    input wire logic [1:0] prio_idx,
    input wire logic [7:0] prio_wr_data,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] x_in,
    input wire logic [7:0] a_in,
    input wire logic [7:0] cc_in,
    input wire logic [7:0] mem_rd_data,
    output logic busy,
    output logic [15:0] stack_pointer,
    output logic level_bit_high,
    output logic level_bit_low,
    output logic [7:0] vector_priority_data,
    output logic [nis_pkg::MASKABLE_VEC-1:0] irq_ack,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wr_data,
    output logic mem_wr,
    output logic mem_rd,
    output logic pc_load,
    output logic [15:0] pc_out,
    output logic ctx_load,
    output logic [7:0] x_out,
    output logic [7:0] a_out,
    output logic [7:0] cc_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int MV = nis_pkg::MASKABLE_VEC;
    localparam int PW = 2 * nis_pkg::NUM_VEC;
    localparam logic [8:0] SP_FIXED = nis_pkg::SP_RESET[15:7];

    typedef struct packed {
        nis_pkg::nis_state_type state;
        logic [2:0] step;
        logic ph;
        logic [6:0] sp;
        logic [1:0] mask;
        logic [1:0] new_mask;
        logic [nis_pkg::NUM_VEC-1:0] pend;
        logic trap_pend;
        logic [8*nis_pkg::PRIO_REGS-1:0] prio;
        logic [7:0] prio_rd;
        logic [39:0] ctx;
        logic [15:0] vaddr;
        logic [MV-1:0] ack;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_wr;
        logic mem_rd;
        logic pc_load;
        logic [15:0] pc;
        logic ctx_load;
        logic [7:0] x;
        logic [7:0] a;
        logic [7:0] cc;
    } nis_regs_type;

    localparam nis_regs_type REG_RESET = '{
        state: nis_pkg::ST_VEC_FETCH,
        sp: nis_pkg::SP_RESET[6:0],
        mask: nis_pkg::LEVEL3_CODE,
        new_mask: nis_pkg::LEVEL3_CODE,
        prio: {nis_pkg::PRIO_REGS{nis_pkg::PRIO_RESET}},
        vaddr: nis_pkg::RESET_VECTOR,
        default: '0
    };

    nis_regs_type q;
    nis_regs_type d;

    logic grant;
    logic [nis_pkg::VEC_IDX_W-1:0] g_idx;
    logic [1:0] g_code;

    // ------------------------------------------------------------
    // Arbitration among maskable vectors 1 to 13
    // ------------------------------------------------------------
    nis_arbiter #(
        .N(MV),
        .W(nis_pkg::VEC_IDX_W)
    ) u_arb (
        .pending(q.pend[nis_pkg::NUM_VEC-1:1]),
        .enable(irq_enable),
        .codes(q.prio[PW-1:2]),
        .cur_code(q.mask),
        .grant(grant),
        .index(g_idx),
        .code(g_code)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [nis_pkg::NUM_VEC-1:0] clr;
        logic trap_clr;
        logic [2:0] cnt;
        logic [2:0] sel;
        logic [6:0] sp_up;
        logic [3:0] vec;
        logic [4:0] base;
        logic [7:0] cc_merged;
        clr = '0;
        trap_clr = 1'b0;
        cnt = nis_pkg::IRQ_CTX_BYTES;
        sel = 3'h0;
        sp_up = 7'(q.sp + 7'h1);
        vec = 4'(g_idx + 4'h1);
        base = {prio_idx, 3'h0};
        cc_merged = cc_in;
        cc_merged[nis_pkg::LEVEL_BIT_HIGH_POS] = q.mask[1];
        cc_merged[nis_pkg::LEVEL_BIT_LOW_POS] = q.mask[0];

        d = q;
        d.ack = '0;
        d.mem_wr = 1'b0;
        d.mem_rd = 1'b0;
        d.pc_load = 1'b0;
        d.ctx_load = 1'b0;
        d.prio_rd = q.prio[base+:8];

        // Read-only upper nibble of the last priority register
        if (prio_wr) begin
            for (int f = 0; f < 4; f++) begin
                if (prio_wr_data[2*f+:2] != nis_pkg::LEVEL0_CODE &&
                    !(prio_idx == 2'h3 &&
                      nis_pkg::PRIO3_RO_MASK[2*f])) begin // [RULE24]
                    d.prio[5'(base + 5'(2*f))+:2] = prio_wr_data[2*f+:2];
                end
            end
        end

        unique case (q.state)
            nis_pkg::ST_IDLE: begin
                if (stack_reset_instruction) begin
                    d.sp = nis_pkg::SP_RESET[6:0]; // [RULE4]
                end else if (sp_load) begin
                    d.sp = sp_load_data[6:0]; // [RULE6] [RULE3]
                end
                if (mask_load) begin
                    d.mask = mask_load_data;
                end
                d.step = 3'h0;
                d.ph = 1'b0;
                if (call_req) begin
                    d.ctx[15:0] = pc_in;
                    d.state = nis_pkg::ST_CALL_PUSH;
                end else if (ret_req) begin
                    d.state = nis_pkg::ST_RET_POP;
                end else if (return_from_handler_instruction) begin
                    d.state = nis_pkg::ST_RTI_POP; // [RULE13]
                end else if (instr_done) begin // [RULE9]
                    // Non-maskable first, pin above trap [RULE20] [RULE22]
                    if (q.pend[0]) begin
                        clr[0] = 1'b1;
                        d.vaddr = nis_pkg::VECTOR_TOP;
                        d.new_mask = nis_pkg::LEVEL3_CODE;
                        d.state = nis_pkg::ST_IRQ_PUSH;
                    end else if (q.trap_pend) begin
                        trap_clr = 1'b1;
                        d.vaddr = nis_pkg::TRAP_VECTOR;
                        d.new_mask = nis_pkg::LEVEL3_CODE;
                        d.state = nis_pkg::ST_IRQ_PUSH;
                    end else if (grant) begin // [RULE18] [RULE21]
                        clr[vec] = 1'b1;
                        d.ack[g_idx] = 1'b1;
                        // Vectors sit two bytes apart below the top one
                        d.vaddr = nis_pkg::VECTOR_TOP -
                            {11'h0, vec, 1'b0}; // [RULE16]
                        d.new_mask = g_code;
                        d.state = nis_pkg::ST_IRQ_PUSH;
                    end
                    // Context snapshot: PROGRAM_COUNTER_LOW_BYTE, PROGRAM_COUNTER_HIGH_BYTE, X, A, CC [RULE10]
                    d.ctx = {cc_merged, a_in, x_in, pc_in[15:8], pc_in[7:0]};
                end
            end

            nis_pkg::ST_IRQ_PUSH, nis_pkg::ST_CALL_PUSH: begin
                cnt = (q.state == nis_pkg::ST_IRQ_PUSH) ?
                    nis_pkg::IRQ_CTX_BYTES : nis_pkg::CALL_BYTES; // [RULE8]
                if (!q.ph) begin
                    // Write at the free slot, then step down [RULE7]
                    d.mem_addr = {SP_FIXED, q.sp}; // [RULE1] [RULE3]
                    d.mem_wdata = q.ctx[{q.step, 3'h0}+:8]; // [RULE25]
                    d.mem_wr = 1'b1;
                    d.sp = 7'(q.sp - 7'h1); // [RULE2] [RULE5]
                    d.ph = 1'b1;
                end else begin
                    d.ph = 1'b0;
                    d.step = 3'(q.step + 3'h1);
                    if (3'(q.step + 3'h1) == cnt) begin
                        d.step = 3'h0;
                        if (q.state == nis_pkg::ST_IRQ_PUSH) begin
                            // Mask changes only after stacking [RULE11]
                            d.mask = q.new_mask; // [RULE22]
                            d.state = nis_pkg::ST_VEC_FETCH;
                        end else begin
                            d.state = nis_pkg::ST_IDLE;
                        end
                    end
                end
            end

            nis_pkg::ST_RTI_POP, nis_pkg::ST_RET_POP: begin
                cnt = (q.state == nis_pkg::ST_RTI_POP) ?
                    nis_pkg::IRQ_CTX_BYTES : nis_pkg::CALL_BYTES;
                sel = 3'(cnt - 3'h1 - q.step); // [RULE25]
                if (!q.ph) begin
                    // Step up first, then read [RULE2] [RULE5]
                    d.sp = sp_up;
                    d.mem_addr = {SP_FIXED, sp_up};
                    d.mem_rd = 1'b1;
                    d.ph = 1'b1;
                end else begin
                    d.ctx[{sel, 3'h0}+:8] = mem_rd_data;
                    d.ph = 1'b0;
                    d.step = 3'(q.step + 3'h1);
                    if (3'(q.step + 3'h1) == cnt) begin
                        d.step = 3'h0;
                        d.pc = d.ctx[15:0];
                        d.pc_load = 1'b1;
                        d.state = nis_pkg::ST_IDLE;
                        if (q.state == nis_pkg::ST_RTI_POP) begin
                            d.x = d.ctx[23:16];
                            d.a = d.ctx[31:24];
                            d.cc = d.ctx[39:32];
                            d.ctx_load = 1'b1;
                            d.mask = {d.ctx[32+nis_pkg::LEVEL_BIT_HIGH_POS],
                                      d.ctx[32+nis_pkg::LEVEL_BIT_LOW_POS]};
                            // [RULE13] [RULE15]
                        end
                    end
                end
            end

            nis_pkg::ST_VEC_FETCH: begin
                if (!q.ph) begin
                    // High byte at the even address, low byte next
                    d.mem_addr = q.vaddr + {15'h0, q.step[0]}; // [RULE17]
                    d.mem_rd = 1'b1;
                    d.ph = 1'b1;
                end else begin
                    d.ph = 1'b0;
                    if (q.step[0]) begin
                        d.pc[7:0] = mem_rd_data;
                        d.pc_load = 1'b1; // [RULE12]
                        d.step = 3'h0;
                        d.state = nis_pkg::ST_IDLE;
                    end else begin
                        d.pc[15:8] = mem_rd_data;
                        d.step = 3'h1;
                    end
                end
            end

            default: begin
                d.state = nis_pkg::ST_IDLE;
            end
        endcase

        // New events win over a clear in the same cycle [RULE19]
        d.pend = (q.pend & ~clr) | {irq_req, top_level_pin_interrupt};
        d.trap_pend = (q.trap_pend & ~trap_clr) | trap_req;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= REG_RESET; // [RULE4] [RULE17]
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy = (q.state != nis_pkg::ST_IDLE);
    assign stack_pointer = {SP_FIXED, q.sp}; // [RULE3]
    assign level_bit_high = q.mask[1]; // [RULE14] [RULE15]
    assign level_bit_low = q.mask[0];
    assign vector_priority_data = q.prio_rd;
    assign irq_ack = q.ack;
    assign mem_addr = q.mem_addr;
    assign mem_wr_data = q.mem_wdata;
    assign mem_wr = q.mem_wr;
    assign mem_rd = q.mem_rd;
    assign pc_load = q.pc_load;
    assign pc_out = q.pc;
    assign ctx_load = q.ctx_load;
    assign x_out = q.x;
    assign a_out = q.a;
    assign cc_out = q.cc;

endmodule

//--- tb/nis_sequencer_sva.sv
// Assertion checker for the nested interrupt and stack sequencer.
// Assumes it is bound to nis_sequencer and sees only that module's ports.
module nis_sequencer_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] pc_in,
    input wire logic [nis_pkg::MASKABLE_VEC-1:0] irq_enable,
    input wire logic busy,
    input wire logic [15:0] stack_pointer,
    input wire logic level_bit_high,
    input wire logic level_bit_low,
    input wire logic [nis_pkg::MASKABLE_VEC-1:0] irq_ack,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic pc_load,
    input wire logic ctx_load
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Stack pointer and entry sequence
    // ------------------------------------------------------------
    property p_sp_upper;
        stack_pointer[15:7] == 9'h002;
    endproperty
    a_sp_upper: assert property (p_sp_upper)
        else $error("stack pointer upper bits moved");
    property p_push_dec;
        mem_wr |-> stack_pointer[6:0] == mem_addr[6:0] - 7'h1;
    endproperty
    a_push_dec: assert property (p_push_dec)
        else $error("pointer not one below the written byte");
    property p_rst_vec;
        mem_rd && mem_addr == 16'hfffe |-> ##2 mem_rd && mem_addr == 16'hffff;
    endproperty
    a_rst_vec: assert property (p_rst_vec)
        else $error("start address fetch out of order");
    // Five writes, then the two vector reads, then the jump
    property p_entry_seq;
        |irq_ack |-> ##1 mem_wr ##2 mem_wr ##2 mem_wr ##2 mem_wr ##2 mem_wr
            ##2 mem_rd ##2 mem_rd ##1 pc_load;
    endproperty
    a_entry_seq: assert property (p_entry_seq)
        else $error("entry sequence has wrong shape");
    property p_nmi_mask;
        mem_rd && (mem_addr == 16'hfffa || mem_addr == 16'hfffc)
            |-> level_bit_high && level_bit_low;
    endproperty
    a_nmi_mask: assert property (p_nmi_mask)
        else $error("non-maskable entry did not raise the mask");
    property p_ctx;
        ctx_load |-> pc_load;
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("context restored without program counter");
    property p_first_byte;
        $rose(busy) ##1 mem_wr |-> mem_wr_data == $past(pc_in[7:0], 2);
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("first pushed byte is not the low pc byte");
    property p_ack;
        |irq_ack |-> $onehot(irq_ack) && (irq_ack & ~$past(irq_enable)) == '0;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not single or not enabled");
endmodule

bind nis_sequencer nis_sequencer_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .pc_in(pc_in), .irq_enable(irq_enable), .busy(busy),
    .stack_pointer(stack_pointer), .level_bit_high(level_bit_high),
    .level_bit_low(level_bit_low), .irq_ack(irq_ack), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .pc_load(pc_load), .ctx_load(ctx_load));

//--- tb/nis_mem_model.sv
// Byte memory on the sequencer's stack and vector side.
// Assumes stack traffic stays in one 128-byte page.
module nis_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ram [0:127];
    logic [7:0] val;
    always @(posedge sys_clk) begin
        if (mem_wr) begin
            ram[mem_addr[6:0]] <= mem_wr_data;
        end
    end
    // Vector space answers its own low address byte, a known pattern
    assign val = (mem_addr[15:8] == 8'hff) ? mem_addr[7:0]
        : ram[mem_addr[6:0]];
    // Outside a read the bus shows the inverse so stale data cannot pass
    assign mem_rd_data = mem_rd ? val : ~val;
endmodule

//--- tb/nested_interrupt_stack_sequencer_tb.sv
// Self-checking bench for the nested interrupt and stack sequencer.
// Assumes the memory model answers reads in the same cycle.
module nested_interrupt_stack_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, instr_done, top_level_pin_interrupt, trap_req;
    logic call_req, ret_req, return_from_handler_instruction;
    logic stack_reset_instruction, sp_load, mask_load, prio_wr;
    logic [12:0] irq_req, irq_enable, irq_ack, last_ack;
    logic [7:0] sp_load_data, prio_wr_data, x_in, a_in, cc_in;
    logic [7:0] mem_rd_data, vector_priority_data, mem_wr_data;
    logic [7:0] x_out, a_out, cc_out;
    logic [1:0] mask_load_data, prio_idx;
    logic [15:0] pc_in, stack_pointer, mem_addr, pc_out, lvl, ack16;
    logic busy, level_bit_high, level_bit_low, mem_wr, mem_rd;
    logic pc_load, ctx_load;
    int mismatches = 0;
    int n_checks = 0;

    nis_sequencer dut (.sys_clk, .rst, .instr_done, .irq_req, .irq_enable,
        .top_level_pin_interrupt, .trap_req, .call_req, .ret_req,
        .return_from_handler_instruction, .stack_reset_instruction,
        .sp_load, .sp_load_data, .mask_load, .mask_load_data, .prio_wr,
        .prio_idx, .prio_wr_data, .pc_in, .x_in, .a_in, .cc_in,
        .mem_rd_data, .busy, .stack_pointer, .level_bit_high,
        .level_bit_low, .vector_priority_data, .irq_ack, .mem_addr,
        .mem_wr_data, .mem_wr, .mem_rd, .pc_load, .pc_out, .ctx_load,
        .x_out, .a_out, .cc_out);
    nis_mem_model u_mem (.sys_clk, .mem_addr, .mem_wr_data, .mem_wr,
        .mem_rd, .mem_rd_data);

    assign lvl = {14'h0, level_bit_high, level_bit_low};
    assign ack16 = {3'h0, last_ack};
    // The acknowledge is a one-cycle pulse; each entry strobe clears it
    always @(posedge sys_clk) if (|irq_ack || instr_done) last_ack <= irq_ack;

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_idle();
        step();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) step();
        chk("busy", 16'h0000, {15'h0, busy});
    endtask
    task automatic enter();
        pulse(instr_done);
        wait_idle();
    endtask
    task automatic ret_irq();
        pulse(return_from_handler_instruction);
        wait_idle();
    endtask
    task automatic prio_rw(input logic [1:0] idx, input logic [7:0] wd,
            input logic [7:0] exp);
        prio_idx = idx;
        prio_wr_data = wd;
        pulse(prio_wr);
        step();
        chk("priority reg", {8'h00, exp}, {8'h00, vector_priority_data});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_stack();
        pc_in = 16'h1234;
        pulse(call_req);
        wait_idle();
        chk("sp after call", 16'h017d, stack_pointer);
        pc_in = 16'h0000;
        pulse(ret_req);
        wait_idle();
        chk("ret pc", 16'h1234, pc_out);
        chk("sp after ret", 16'h017f, stack_pointer);
        sp_load_data = 8'h80;
        pulse(sp_load);
        chk("sp loaded", 16'h0100, stack_pointer);
        pulse(call_req);
        wait_idle();
        chk("sp wrapped", 16'h017e, stack_pointer);
        pulse(stack_reset_instruction);
        chk("sp reset", 16'h017f, stack_pointer);
        $display("test stack done");
    endtask
    task automatic t_prio();
        prio_rw(2'h0, 8'hc7, 8'hc7);
        prio_rw(2'h0, 8'h22, 8'h03);
        prio_rw(2'h0, 8'hc7, 8'hc7);
        prio_rw(2'h3, 8'h00, 8'hf0);
        $display("test priority done");
    endtask
    task automatic t_nest();
        mask_load_data = 2'h2;
        pulse(mask_load);
        irq_req = 13'h0003;
        step();
        irq_req = 13'h0000;
        pc_in = 16'h1234;
        enter();
        chk("ack", 16'h0002, ack16);
        chk("handler pc", 16'hf6f7, pc_out);
        chk("mask", 16'h0000, lvl);
        chk("stacked pcl", 16'h0034, {8'h0, u_mem.ram[7'h7f]});
        chk("stacked pch", 16'h0012, {8'h0, u_mem.ram[7'h7e]});
        chk("stacked x", 16'h0011, {8'h0, u_mem.ram[7'h7d]});
        chk("stacked cc", 16'h0020, {8'h0, u_mem.ram[7'h7b]});
        enter();
        chk("lower level held", 16'h0000, ack16);
        pc_in = 16'h5678;
        pulse(top_level_pin_interrupt);
        step();
        chk("entry before end", 16'h0000, {15'h0, busy});
        enter();
        chk("pin pc", 16'hfafb, pc_out);
        chk("pin mask", 16'h0003, lvl);
        ret_irq();
        chk("resume pc", 16'h5678, pc_out);
        chk("resume mask", 16'h0000, lvl);
        ret_irq();
        chk("main pc", 16'h1234, pc_out);
        chk("main a", 16'h0022, {8'h0, a_out});
        chk("main x", 16'h0011, {8'h0, x_out});
        chk("main cc", 16'h0020, {8'h0, cc_out});
        chk("main mask", 16'h0002, lvl);
        irq_enable = 13'h1ffe;
        enter();
        chk("disabled held", 16'h0000, ack16);
        irq_enable = 13'h1fff;
        enter();
        chk("late ack", 16'h0001, ack16);
        chk("vector one pc", 16'hf8f9, pc_out);
        chk("vector one mask", 16'h0001, lvl);
        ret_irq();
        $display("test nesting done");
    endtask
    task automatic t_trap();
        pc_in = 16'h4321;
        pulse(trap_req);
        enter();
        chk("trap pc", 16'hfcfd, pc_out);
        chk("trap mask", 16'h0003, lvl);
        ret_irq();
        chk("trap return", 16'h4321, pc_out);
        $display("test trap done");
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end

    initial begin
        {rst, instr_done, top_level_pin_interrupt, trap_req} = 4'h8;
        {call_req, ret_req, return_from_handler_instruction} = 3'h0;
        {stack_reset_instruction, sp_load, mask_load, prio_wr} = 4'h0;
        irq_req = '0;
        irq_enable = 13'h1fff;
        {sp_load_data, prio_wr_data, mask_load_data, prio_idx} = '0;
        {x_in, a_in, cc_in, pc_in} = {8'h11, 8'h22, 8'h00, 16'h0000};
        repeat (5) step();
        chk("reset sp", 16'h017f, stack_pointer);
        chk("reset mask", 16'h0003, lvl);
        rst = 1'b0;
        wait_idle();
        chk("start pc", 16'hfeff, pc_out);
        $display("test reset done");
        t_stack();
        t_prio();
        t_nest();
        t_trap();
        end_sim();
    end
endmodule
